/* inc/dcl_pkg.sv */
// Shared constants and types for the DMA channel limit and control block
package dcl_pkg;

	// ****************************************************************
	// Register map (byte offsets)
	// ****************************************************************
	localparam logic [4:0] OFS_MEM_ADDR = 5'h04;
	localparam logic [4:0] OFS_MEM_END  = 5'h08;
	localparam logic [4:0] OFS_DEV_ADDR = 5'h0C;
	localparam logic [4:0] OFS_CTRL     = 5'h10;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
	localparam logic [4:0] OFS_IRQ_EN   = 5'h18;
	localparam logic [4:0] OFS_IRQ_CLR  = 5'h1C;

	// ****************************************************************
	// Control register field positions
	// ****************************************************************
	localparam int CTL_ABORT   = 25;
	localparam int CTL_GO      = 24;
	localparam int CTL_SIZE_HI = 22;
	localparam int CTL_SIZE_LO = 20;
	localparam int CTL_HFC_DIS = 19;
	localparam int CTL_INC_DEV = 17;
	localparam int CTL_INC_MEM = 16;
	localparam int CTL_DIR     = 8;

	// ****************************************************************
	// Interrupt status bit positions
	// ****************************************************************
	localparam int IRQ_W       = 3;
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_ABORT   = 1;
	localparam int IRQ_TERM    = 2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0]      ADDR_RST  = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_RST   = 3'h0;
	localparam logic [31:0]      RDATA_RST = 32'h0000_0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic       abort;
		logic       go;
		logic [2:0] size;
		logic       hfc_dis;
		logic       inc_dev;
		logic       inc_mem;
		logic       dir;
	} dcl_ctrl_t;

	localparam dcl_ctrl_t CTRL_RST = '{abort: 1'b0, go: 1'b0, size: 3'h0, hfc_dis: 1'b0,
		inc_dev: 1'b0, inc_mem: 1'b0, dir: 1'b0};

	typedef struct packed {
		logic req;
		logic term;
	} dcl_fc_t;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic [31:0] addr;
		logic [2:0]  size;
		logic [31:0] wdata;
	} dcl_bm_t;

	localparam dcl_bm_t BM_RST = '{req: 1'b0, wr: 1'b0, addr: 32'h0000_0000, size: 3'h0,
		wdata: 32'h0000_0000};

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RD   = 2'b01,
		ST_WR   = 2'b11,
		ST_FIN  = 2'b10
	} dcl_state_t;

endpackage : dcl_pkg

/* src/dcl_sync.sv */
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/100ps
module dcl_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : dcl_sync

/* src/dcl_channel.sv */
// One DMA channel: address limit, device address, control and flow control
// Operation
// - Memory address reaching end raises done when memory auto-increment is on
// - Address bits above bus width read zero
// - Device address addresses flow-control peripheral
// - Device address grows by packet size
// - Abort stops the transfer at once
// - Go starts software-paced transfer
// - Flow-control disable ignores all peripheral signalling
// - Memory address auto-increments when enabled
// - Device address auto-increments when enabled
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
module dcl_channel #(
	parameter int AW = 32
) (
	// Clock and reset
	input  wire logic           clock,
	input  wire logic           nrst,
	// Avalon-MM register slave
	input  wire logic [4:0]     avs_address,
	input  wire logic           avs_read,
	input  wire logic           avs_write,
	input  wire logic [31:0]    avs_writedata,
	input  wire logic [3:0]     avs_byteenable,
	output logic      [31:0]    avs_readdata,
	output logic                avs_waitrequest,
	// Flow-control interface (pins)
	input  wire dcl_pkg::dcl_fc_t fc_in,
	output logic                fc_done,
	// System bus master
	output dcl_pkg::dcl_bm_t    bm_out,
	input  wire logic           bm_ack,
	input  wire logic [31:0]    bm_rdata,
	// Interrupt
	output logic                irq
);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (AW < 1 || AW > 32)
	begin : g_aw_check
		$error("AW must lie between 1 and 32");
	end

	// ****************************************************************
	// Flow-control synchronisation
	// ****************************************************************
	dcl_pkg::dcl_fc_t fc_s;

	dcl_sync #(
		.W        (2)
	) u_fc_sync (
		.clock    (clock),
		.nrst     (nrst),
		.async_in (fc_in),
		.sync_out (fc_s)
	);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [31:0]                 addr_mask;
	logic                        wr_hit;
	logic                        rd_hit;

	logic                        wait_q;
	logic                        wait_d;
	logic [31:0]                 rdata_q;
	logic [31:0]                 rdata_d;

	logic [AW-1:0]               mem_q;
	logic [AW-1:0]               mem_d;
	logic [AW-1:0]               end_q;
	logic [AW-1:0]               end_d;
	logic [AW-1:0]               dev_q;
	logic [AW-1:0]               dev_d;
	dcl_pkg::dcl_ctrl_t          ctrl_q;
	dcl_pkg::dcl_ctrl_t          ctrl_d;
	logic [dcl_pkg::IRQ_W-1:0]   stat_q;
	logic [dcl_pkg::IRQ_W-1:0]   stat_d;
	logic [dcl_pkg::IRQ_W-1:0]   ien_q;
	logic [dcl_pkg::IRQ_W-1:0]   ien_d;
	dcl_pkg::dcl_state_t         state_q;
	dcl_pkg::dcl_state_t         state_d;
	dcl_pkg::dcl_bm_t            bm_q;
	dcl_pkg::dcl_bm_t            bm_d;
	logic [31:0]                 data_q;
	logic [31:0]                 data_d;
	logic                        done_q;
	logic                        done_d;
	logic                        irq_q;
	logic                        irq_d;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : be_merge

	function automatic logic [31:0] ctrl_pack(input dcl_pkg::dcl_ctrl_t c);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[dcl_pkg::CTL_ABORT]                         = c.abort;
		r[dcl_pkg::CTL_GO]                            = c.go;
		r[dcl_pkg::CTL_SIZE_HI:dcl_pkg::CTL_SIZE_LO] = c.size;
		r[dcl_pkg::CTL_HFC_DIS]                       = c.hfc_dis;
		r[dcl_pkg::CTL_INC_DEV]                       = c.inc_dev;
		r[dcl_pkg::CTL_INC_MEM]                       = c.inc_mem;
		r[dcl_pkg::CTL_DIR]                           = c.dir;
		return r;
	endfunction : ctrl_pack

	function automatic dcl_pkg::dcl_ctrl_t ctrl_unpack(input logic [31:0] v);
		dcl_pkg::dcl_ctrl_t c;
		c.abort   = v[dcl_pkg::CTL_ABORT];
		c.go      = v[dcl_pkg::CTL_GO];
		c.size    = v[dcl_pkg::CTL_SIZE_HI:dcl_pkg::CTL_SIZE_LO];
		c.hfc_dis = v[dcl_pkg::CTL_HFC_DIS];
		c.inc_dev = v[dcl_pkg::CTL_INC_DEV];
		c.inc_mem = v[dcl_pkg::CTL_INC_MEM];
		c.dir     = v[dcl_pkg::CTL_DIR];
		return c;
	endfunction : ctrl_unpack

	function automatic logic [31:0] zx(input logic [AW-1:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[AW-1:0] = a;
		return r;
	endfunction : zx

	assign addr_mask = zx('1);
	assign wr_hit    = avs_write && !wait_q;
	assign rd_hit    = avs_read && wait_q;

	// ****************************************************************
	// Bus slave handshake and read data
	// ****************************************************************
	always_comb
	begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if ((avs_read || avs_write) && wait_q)
			wait_d = 1'b0;
		if (rd_hit)
		begin
			unique case (avs_address)
				dcl_pkg::OFS_MEM_ADDR: rdata_d = zx(mem_q);
				dcl_pkg::OFS_MEM_END:  rdata_d = zx(end_q);
				dcl_pkg::OFS_DEV_ADDR: rdata_d = zx(dev_q);
				dcl_pkg::OFS_CTRL:     rdata_d = ctrl_pack(ctrl_q);
				dcl_pkg::OFS_IRQ_STAT: rdata_d = {29'h0000_0000, stat_q};
				dcl_pkg::OFS_IRQ_EN:   rdata_d = {29'h0000_0000, ien_q};
				default:               rdata_d = dcl_pkg::RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			wait_q  <= 1'b1;
			rdata_q <= dcl_pkg::RDATA_RST;
		end
		else
		begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// Channel registers and transfer engine
	// ****************************************************************
	always_comb
	begin
		logic          at_end;
		logic [AW-1:0] step;
		logic [AW-1:0] mem_nx;
		logic          busy;
		logic          hw_ok;
		logic [dcl_pkg::IRQ_W-1:0] ev;
		logic [dcl_pkg::IRQ_W-1:0] clr;
		at_end  = ctrl_q.inc_mem && (mem_q == end_q);
		step    = AW'(ctrl_q.size);
		mem_nx  = mem_q + step;
		busy    = (state_q != dcl_pkg::ST_IDLE);
		hw_ok   = !ctrl_q.hfc_dis;
		ev      = '0;
		clr     = '0;
		mem_d   = mem_q;
		end_d   = end_q;
		dev_d   = dev_q;
		ctrl_d  = ctrl_q;
		ien_d   = ien_q;
		state_d = state_q;
		bm_d    = bm_q;
		data_d  = data_q;
		done_d  = 1'b0;

		// Software writes
		if (wr_hit)
		begin
			unique case (avs_address)
				dcl_pkg::OFS_MEM_ADDR:
					mem_d = AW'(be_merge(zx(mem_q), avs_writedata, avs_byteenable)
						& addr_mask);
				dcl_pkg::OFS_MEM_END:
					end_d = AW'(be_merge(zx(end_q), avs_writedata, avs_byteenable)
						& addr_mask);
				dcl_pkg::OFS_DEV_ADDR:
					dev_d = AW'(be_merge(zx(dev_q), avs_writedata, avs_byteenable)
						& addr_mask);
				dcl_pkg::OFS_CTRL:
					ctrl_d = ctrl_unpack(be_merge(ctrl_pack(ctrl_q), avs_writedata,
						avs_byteenable));
				dcl_pkg::OFS_IRQ_EN:
					ien_d = avs_writedata[dcl_pkg::IRQ_W-1:0] & {dcl_pkg::IRQ_W{avs_byteenable[0]}};
				dcl_pkg::OFS_IRQ_CLR:
					clr = avs_writedata[dcl_pkg::IRQ_W-1:0] & {dcl_pkg::IRQ_W{avs_byteenable[0]}};
				default:
					;
			endcase
		end

		// Transfer engine
		unique case (state_q)
			dcl_pkg::ST_IDLE:
			begin
				// A stale request after the end is reached must not restart
				if (!ctrl_q.abort && !at_end && ((ctrl_q.hfc_dis && ctrl_q.go)
					|| (hw_ok && fc_s.req && !fc_s.term)))
					state_d = dcl_pkg::ST_RD;
			end
			dcl_pkg::ST_RD:
			begin
				bm_d.req  = 1'b1;
				bm_d.wr   = 1'b0;
				bm_d.size = ctrl_q.size;
				bm_d.addr = ctrl_q.dir ? zx(mem_q) : zx(dev_q);
				if (bm_q.req && bm_ack)
				begin
					bm_d.req  = 1'b0;
					data_d    = bm_rdata;
					state_d   = dcl_pkg::ST_WR;
				end
			end
			dcl_pkg::ST_WR:
			begin
				bm_d.req   = 1'b1;
				bm_d.wr    = 1'b1;
				bm_d.wdata = data_q;
				bm_d.addr  = ctrl_q.dir ? zx(dev_q) : zx(mem_q);
				if (bm_q.req && bm_ack)
				begin
					bm_d.req = 1'b0;
					bm_d.wr  = 1'b0;
					state_d  = dcl_pkg::ST_FIN;
					if (ctrl_q.inc_mem)
						mem_d = mem_nx;
					if (ctrl_q.inc_dev)
						dev_d = dev_q + step;
				end
			end
			dcl_pkg::ST_FIN:
			begin
				if (ctrl_q.inc_mem && mem_q == end_q)
				begin
					ev[dcl_pkg::IRQ_DONE] = 1'b1;
					done_d   = hw_ok;
					ctrl_d.go = 1'b0;
					state_d  = dcl_pkg::ST_IDLE;
				end
				else if (ctrl_q.hfc_dis && ctrl_q.go)
					state_d = dcl_pkg::ST_RD;
				else
					state_d = dcl_pkg::ST_IDLE;
			end
		endcase

		// Peripheral terminate ends an active transfer
		if (busy && hw_ok && fc_s.term)
		begin
			ev[dcl_pkg::IRQ_TERM] = 1'b1;
			state_d = dcl_pkg::ST_IDLE;
			bm_d    = dcl_pkg::BM_RST;
		end

		// Abort stops everything at once
		if (busy && (ctrl_q.abort || ctrl_d.abort))
		begin
			ev[dcl_pkg::IRQ_ABORT] = 1'b1;
			ctrl_d.go = 1'b0;
			state_d   = dcl_pkg::ST_IDLE;
			bm_d      = dcl_pkg::BM_RST;
			done_d    = 1'b0;
		end

		// Set wins over clear
		stat_d = (stat_q & ~clr) | ev;
		irq_d  = |(stat_d & ien_d);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			mem_q   <= dcl_pkg::ADDR_RST[AW-1:0];
			end_q   <= dcl_pkg::ADDR_RST[AW-1:0];
			dev_q   <= dcl_pkg::ADDR_RST[AW-1:0];
			ctrl_q  <= dcl_pkg::CTRL_RST;
			stat_q  <= dcl_pkg::IRQ_RST;
			ien_q   <= dcl_pkg::IRQ_RST;
			state_q <= dcl_pkg::ST_IDLE;
			bm_q    <= dcl_pkg::BM_RST;
			data_q  <= dcl_pkg::RDATA_RST;
			done_q  <= 1'b0;
			irq_q   <= 1'b0;
		end
		else
		begin
			mem_q   <= mem_d;
			end_q   <= end_d;
			dev_q   <= dev_d;
			ctrl_q  <= ctrl_d;
			stat_q  <= stat_d;
			ien_q   <= ien_d;
			state_q <= state_d;
			bm_q    <= bm_d;
			data_q  <= data_d;
			done_q  <= done_d;
			irq_q   <= irq_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign bm_out          = bm_q;
	assign fc_done         = done_q;
	assign irq             = irq_q;

endmodule : dcl_channel

/* tb/dcl_checker.sv */
// Port-level assertions for the DMA channel
`timescale 1ns/100ps
module dcl_checker #(
	parameter int AW = 32
) (
	// Clock and reset
	input wire logic             clock,
	input wire logic             nrst,
	// Register bus
	input wire logic [4:0]       avs_address,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic [31:0]      avs_writedata,
	input wire logic [31:0]      avs_readdata,
	input wire logic             avs_waitrequest,
	// Flow control and system bus
	input wire logic             fc_done,
	input wire dcl_pkg::dcl_bm_t bm_out
);
	// ****************************************************************
	// Shadow of control bits
	// ****************************************************************
	localparam logic [31:0] AMASK = (AW >= 32) ? 32'hFFFF_FFFF : ((32'h1 << AW) - 32'h1);
	logic ctl_w;
	logic rd_ok;
	logic hfc_q, hfc_d, abort_q, abort_d;
	assign ctl_w = avs_write && !avs_waitrequest && avs_address == dcl_pkg::OFS_CTRL;
	assign rd_ok = avs_read && !avs_waitrequest;
	always_comb
	begin
		hfc_d   = ctl_w ? avs_writedata[19] : hfc_q;
		abort_d = ctl_w ? avs_writedata[25] : abort_q;
	end
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			hfc_q   <= 1'b0;
			abort_q <= 1'b0;
		end
		else
		begin
			hfc_q   <= hfc_d;
			abort_q <= abort_d;
		end
	end
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register access not answered in one cycle");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	done_pulse_a: assert property (fc_done |=> !fc_done)
		else $error("done pulse longer than one cycle");
	abort_stop_a: assert property (abort_q[*2] |-> !bm_out.req)
		else $error("bus request while aborted");
	go_start_a: assert property (ctl_w && avs_writedata[24] && avs_writedata[19]
		&& !avs_writedata[25] |-> ##[1:8] bm_out.req) else $error("go did not start a transfer");
	hfc_quiet_a: assert property (hfc_q[*2] |-> !fc_done)
		else $error("done signalled while flow control disabled");
	ctrl_rsvd_a: assert property (rd_ok && avs_address == dcl_pkg::OFS_CTRL
		|-> (avs_readdata & 32'hFC84_FEFF) == 32'h0) else $error("reserved control bit set");
	addr_width_a: assert property (rd_ok && avs_address inside {5'h04, 5'h08, 5'h0C}
		|-> (avs_readdata & ~AMASK) == 32'h0) else $error("address bit above bus width");
	bus_width_a: assert property (bm_out.req |-> (bm_out.addr & ~AMASK) == 32'h0)
		else $error("bus address above bus width");
	cover property (fc_done);
	cover property (ctl_w && avs_writedata[24]);
	cover property (abort_q && $fell(bm_out.req));
endmodule : dcl_checker

bind dcl_channel dcl_checker #(.AW(AW)) chk_u (.clock, .nrst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .fc_done, .bm_out);

/* tb/dcl_periph.sv */
// Flow-control peripheral and system bus memory model
`timescale 1ns/100ps
module dcl_periph (
	// Clock and reset
	input wire logic             clock,
	input wire logic             nrst,
	// Bench commands
	input wire logic             want,
	input wire logic             term,
	input wire logic [3:0]       delay,
	// Channel side
	input wire logic             fc_done,
	input wire dcl_pkg::dcl_bm_t bm_out,
	output dcl_pkg::dcl_fc_t     fc_in,
	output logic                 bm_ack,
	output logic [31:0]          bm_rdata,
	// Observations
	output logic [31:0]          last_wr_addr,
	output logic [31:0]          last_wr_data,
	output logic [31:0]          last_rd_addr,
	output logic [7:0]           wr_count,
	output logic [7:0]           done_count
);
	logic       req_q, cut_q;
	logic [3:0] wait_q;
	assign fc_in = '{req: req_q, term: term};
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			{req_q, cut_q, bm_ack, wait_q, wr_count, done_count} <= '0;
			{bm_rdata, last_wr_addr, last_wr_data, last_rd_addr} <= '0;
		end
		else
		begin
			// Request held until done, then withdrawn
			req_q    <= want && !fc_done && !cut_q;
			cut_q    <= want && (cut_q || fc_done);
			bm_ack   <= 1'b0;
			wait_q   <= 4'h0;
			// Data lines toggle except when answering a read
			bm_rdata <= ~bm_rdata;
			if (fc_done)
				done_count <= done_count + 8'h1;
			if (bm_out.req && !bm_ack)
			begin
				wait_q <= wait_q + 4'h1;
				if (wait_q == delay)
				begin
					bm_ack <= 1'b1;
					if (bm_out.wr)
					begin
						last_wr_addr <= bm_out.addr;
						last_wr_data <= bm_out.wdata;
						wr_count     <= wr_count + 8'h1;
					end
					else
					begin
						last_rd_addr <= bm_out.addr;
						bm_rdata     <= bm_out.addr ^ 32'h5A5A_0000;
					end
				end
			end
		end
	end
endmodule : dcl_periph

/* tb/dma_channel_limit_and_control_tb.sv */
// Register-level testbench for the DMA channel
`timescale 1ns/100ps
module dma_channel_limit_and_control_tb;
	logic             clock, nrst, avs_read, avs_write, avs_waitrequest, fc_done, bm_ack, irq;
	logic [4:0]       avs_address;
	logic [31:0]      avs_writedata, avs_readdata, bm_rdata, wa, wd, ra, q;
	logic [3:0]       delay;
	logic             want, term;
	logic [7:0]       wr_count, done_count, wc;
	dcl_pkg::dcl_fc_t fc_in;
	dcl_pkg::dcl_bm_t bm_out;
	int               bad_count, checked;

	dcl_channel #(.AW(24)) dut_u (.clock, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .fc_in,
		.fc_done, .bm_out, .bm_ack, .bm_rdata, .irq);
	dcl_periph per_u (.clock, .nrst, .want, .term, .delay, .fc_done, .bm_out, .fc_in,
		.bm_ack, .bm_rdata, .last_wr_addr(wa), .last_wr_data(wd), .last_rd_addr(ra),
		.wr_count, .done_count);

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= d;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0)
			@(posedge clock);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask : rchk

	task automatic wait_done();
		int n;
		n = 0;
		q = 32'h0;
		while (q[0] !== 1'b1 && n < 200)
		begin
			bus(1'b0, dcl_pkg::OFS_IRQ_STAT, 32'h0);
			n++;
		end
	endtask : wait_done

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial
	begin
		#100us;
		bad_count++;
		end_sim();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial
	begin
		{nrst, avs_read, avs_write, want, term, avs_address, avs_writedata} = '0;
		{bad_count, checked} = '0;
		delay = 4'h0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rchk(dcl_pkg::OFS_MEM_END, 32'h0);
		rchk(dcl_pkg::OFS_CTRL, 32'h0);
		bus(1'b1, 5'h00, 32'hFFFF_FFFF);
		rchk(5'h00, 32'h0);
		bus(1'b1, dcl_pkg::OFS_MEM_END, 32'hFFFF_FFFF);
		rchk(dcl_pkg::OFS_MEM_END, 32'h00FF_FFFF);
		bus(1'b1, dcl_pkg::OFS_DEV_ADDR, 32'hFFFF_FFFF);
		rchk(dcl_pkg::OFS_DEV_ADDR, 32'h00FF_FFFF);
		bus(1'b1, dcl_pkg::OFS_CTRL, 32'hFEFF_FFFF);
		rchk(dcl_pkg::OFS_CTRL, 32'h027B_0100);
		// Software-paced, memory to device, size 4
		bus(1'b1, dcl_pkg::OFS_MEM_ADDR, 32'h0000_0100);
		bus(1'b1, dcl_pkg::OFS_MEM_END, 32'h0000_0108);
		bus(1'b1, dcl_pkg::OFS_DEV_ADDR, 32'h0000_2000);
		bus(1'b1, dcl_pkg::OFS_CTRL, 32'h014B_0100);
		wait_done();
		chk("done", 32'h1, q);
		rchk(dcl_pkg::OFS_MEM_ADDR, 32'h0000_0108);
		rchk(dcl_pkg::OFS_DEV_ADDR, 32'h0000_2008);
		chk("writes", 32'h2, {24'h0, wr_count});
		chk("write addr", 32'h0000_2004, wa);
		chk("write data", 32'h5A5A_0104, wd);
		chk("irq masked", 32'h0, {31'h0, irq});
		bus(1'b1, dcl_pkg::OFS_IRQ_EN, 32'h1);
		@(posedge clock);
		chk("irq set", 32'h1, {31'h0, irq});
		bus(1'b1, dcl_pkg::OFS_IRQ_CLR, 32'h1);
		@(posedge clock);
		chk("irq clear", 32'h0, {31'h0, irq});
		// Peripheral signalling ignored while disabled
		bus(1'b1, dcl_pkg::OFS_CTRL, 32'h0008_0000);
		want <= 1'b1;
		repeat (20) @(posedge clock);
		chk("ignored writes", 32'h2, {24'h0, wr_count});
		rchk(dcl_pkg::OFS_IRQ_STAT, 32'h0);
		term <= 1'b0;
		// Hardware-paced, device to memory, size 1
		bus(1'b1, dcl_pkg::OFS_MEM_ADDR, 32'h0000_0200);
		bus(1'b1, dcl_pkg::OFS_MEM_END, 32'h0000_0202);
		bus(1'b1, dcl_pkg::OFS_DEV_ADDR, 32'h0000_3000);
		bus(1'b1, dcl_pkg::OFS_CTRL, 32'h0011_0000);
		wait_done();
		chk("hw done", 32'h1, {24'h0, done_count});
		rchk(dcl_pkg::OFS_MEM_ADDR, 32'h0000_0202);
		rchk(dcl_pkg::OFS_DEV_ADDR, 32'h0000_3000);
		chk("dev read", 32'h0000_3000, ra);
		chk("mem write", 32'h0000_0201, wa);
		chk("hw writes", 32'h4, {24'h0, wr_count});
		want <= 1'b0;
		// Abort in mid-transfer, fixed memory address, size 2
		bus(1'b1, dcl_pkg::OFS_IRQ_CLR, 32'h7);
		bus(1'b1, dcl_pkg::OFS_MEM_ADDR, 32'h0000_0300);
		delay <= 4'h8;
		bus(1'b1, dcl_pkg::OFS_CTRL, 32'h0020_0000);
		want <= 1'b1;
		repeat (60) @(posedge clock);
		rchk(dcl_pkg::OFS_MEM_ADDR, 32'h0000_0300);
		bus(1'b1, dcl_pkg::OFS_CTRL, 32'h0220_0000);
		wc = wr_count;
		rchk(dcl_pkg::OFS_IRQ_STAT, 32'h2);
		repeat (30) @(posedge clock);
		chk("after abort", {24'h0, wc}, {24'h0, wr_count});
		// Peripheral terminate in mid-transfer
		bus(1'b1, dcl_pkg::OFS_IRQ_CLR, 32'h7);
		bus(1'b1, dcl_pkg::OFS_CTRL, 32'h0020_0000);
		repeat (15) @(posedge clock);
		term <= 1'b1;
		repeat (10) @(posedge clock);
		rchk(dcl_pkg::OFS_IRQ_STAT, 32'h4);
		term <= 1'b0;
		want <= 1'b0;
		end_sim();
	end
endmodule : dma_channel_limit_and_control_tb
